/* eic_pkg.sv */
// constants for the external interrupt configuration and priority block
package eic_pkg;

    // ==========================================================
    // register addresses on the special function register port
    localparam logic [7:0] EIC_PIN_CFG_ADDR = 8'he4;
    localparam logic [7:0] EIC_PRIO_TWO_ADDR = 8'hf7;
    localparam logic [7:0] EIC_TIMER_CTRL_ADDR = 8'h88;

    // ==========================================================
    // reset values and write masks
    localparam logic [7:0] EIC_PIN_CFG_RESET = 8'h01;
    localparam logic [7:0] EIC_PRIO_TWO_RESET = 8'h00;
    localparam logic [7:0] EIC_PRIO_TWO_WMASK = 8'h3f;
    localparam logic [7:0] EIC_ZERO_BYTE = 8'h00;
    // port pins idle high on their pull-ups
    localparam logic [7:0] EIC_PIN_IDLE = 8'hff;

    // ==========================================================
    // priority register field positions
    localparam int EIC_TIMER5_BIT = 5;
    localparam int EIC_TIMER4_BIT = 4;
    localparam int EIC_SMBUS_BIT = 3;
    localparam int EIC_SERIAL_BIT = 1;
    localparam int EIC_LEVEL_BIT = 0;

    // ==========================================================
    // pin configuration field positions
    localparam int EIC_B_POL_BIT = 7;
    localparam int EIC_B_SEL_LSB = 4;
    localparam int EIC_A_POL_BIT = 3;
    localparam int EIC_A_SEL_LSB = 0;
    localparam int EIC_SEL_WIDTH = 3;

    // ==========================================================
    // timer control bits owned by this block
    localparam int EIC_TRIG_A_BIT = 0;
    localparam int EIC_PEND_A_BIT = 1;
    localparam int EIC_TRIG_B_BIT = 2;
    localparam int EIC_PEND_B_BIT = 3;

    // ==========================================================
    // whole state of the block
    typedef struct packed {
        logic [7:0] syncFirst;
        logic [7:0] syncSecond;
        logic [7:0] pinCfg;
        logic [7:0] prioTwo;
        logic trigA;
        logic trigB;
        logic pendA;
        logic pendB;
        logic prevA;
        logic prevB;
        logic levelReq;
        logic [7:0] readData;
    } eic_state_type;

endpackage : eic_pkg

/* eic_ext_irq_config.sv */
// external interrupt pin configuration, pending flags and second priority register
`timescale 1ns/100ps

// What this block does
// - priority bits five and four: timers five, four
// - priority bit three: second smbus interrupt
// - priority bit one: second serial port
// - priority bit zero: level interrupt c
// - bits seven, six read zero; reset zero
// - trigger bit one edge, zero level
// - bits seven, three set b, a polarity
// - three-bit fields pick port zero pin
// - config resets to one; a P0.1, b P0.0
// - pins sampled only, never driven
// - control bits one, three are pending flags
// - edge pending clears on vector
// - level pending follows active input level
// - level interrupt c gated by enable bit
module eic_ext_irq_config (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWriteData,
    output logic [7:0] sfrReadData,
    input wire logic [7:0] port0Pins,
    input wire logic extAVectorAck,
    input wire logic extBVectorAck,
    input wire logic levelIrqEnable,
    input wire logic levelIrqCActive,
    output logic extAPending,
    output logic extBPending,
    output logic extATriggerType,
    output logic extBTriggerType,
    output logic levelIrqCRequest,
    output logic timer5Priority,
    output logic timer4Priority,
    output logic secondSmbusPriority,
    output logic serialOnePriority,
    output logic levelIrqPriority
);

    // ==========================================================
    // state and decode
    eic_pkg::eic_state_type state_reg;
    eic_pkg::eic_state_type state_next;
    logic [2:0] selA;
    logic [2:0] selB;
    logic activeA;
    logic activeB;
    logic edgeA;
    logic edgeB;
    logic wrCfg;
    logic wrPrio;
    logic wrCtrl;

    assign selA = state_reg.pinCfg[eic_pkg::EIC_A_SEL_LSB +: eic_pkg::EIC_SEL_WIDTH];
    assign selB = state_reg.pinCfg[eic_pkg::EIC_B_SEL_LSB +: eic_pkg::EIC_SEL_WIDTH];
    // polarity bit equal to the pin level means active
    assign activeA = state_reg.syncSecond[selA] == state_reg.pinCfg[eic_pkg::EIC_A_POL_BIT];
    assign activeB = state_reg.syncSecond[selB] == state_reg.pinCfg[eic_pkg::EIC_B_POL_BIT];
    assign edgeA = activeA && !state_reg.prevA;
    assign edgeB = activeB && !state_reg.prevB;
    assign wrCfg = sfrWrite && (sfrAddr == eic_pkg::EIC_PIN_CFG_ADDR);
    assign wrPrio = sfrWrite && (sfrAddr == eic_pkg::EIC_PRIO_TWO_ADDR);
    assign wrCtrl = sfrWrite && (sfrAddr == eic_pkg::EIC_TIMER_CTRL_ADDR);

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        // pins are only read here; whatever the crossbar routes keeps the pin
        state_next.syncFirst = port0Pins;
        state_next.syncSecond = state_reg.syncFirst;
        state_next.prevA = activeA;
        state_next.prevB = activeB;

        if (wrCfg) begin
            state_next.pinCfg = sfrWriteData;
        end
        if (wrPrio) begin
            // bit two is kept as plain storage, bits seven and six drop
            state_next.prioTwo = sfrWriteData & eic_pkg::EIC_PRIO_TWO_WMASK;
        end
        if (wrCtrl) begin
            state_next.trigA = sfrWriteData[eic_pkg::EIC_TRIG_A_BIT];
            state_next.trigB = sfrWriteData[eic_pkg::EIC_TRIG_B_BIT];
            state_next.pendA = sfrWriteData[eic_pkg::EIC_PEND_A_BIT];
            state_next.pendB = sfrWriteData[eic_pkg::EIC_PEND_B_BIT];
        end

        // channel a: clear by vector or write first, a new edge wins over both
        if (state_reg.trigA) begin
            if (extAVectorAck) begin
                state_next.pendA = 1'b0;
            end
            if (edgeA) begin
                state_next.pendA = 1'b1;
            end
        end else begin
            // level mode tracks the pin; a software write is overridden
            state_next.pendA = activeA;
        end

        if (state_reg.trigB) begin
            if (extBVectorAck) begin
                state_next.pendB = 1'b0;
            end
            if (edgeB) begin
                state_next.pendB = 1'b1;
            end
        end else begin
            state_next.pendB = activeB;
        end

        state_next.levelReq = levelIrqEnable && levelIrqCActive;

        if (sfrRead) begin
            unique case (sfrAddr)
                eic_pkg::EIC_PIN_CFG_ADDR: begin
                    state_next.readData = state_reg.pinCfg;
                end
                eic_pkg::EIC_PRIO_TWO_ADDR: begin
                    state_next.readData = state_reg.prioTwo & eic_pkg::EIC_PRIO_TWO_WMASK;
                end
                eic_pkg::EIC_TIMER_CTRL_ADDR: begin
                    // upper control bits belong to the timers and read zero here
                    state_next.readData = {4'h0, state_reg.pendB, state_reg.trigB,
                                           state_reg.pendA, state_reg.trigA};
                end
                default: begin
                    state_next.readData = eic_pkg::EIC_ZERO_BYTE;
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // synchroniser starts at the idle pin level, else active-low inputs pend falsely after reset
            state_reg <= '{syncFirst: eic_pkg::EIC_PIN_IDLE,
                           syncSecond: eic_pkg::EIC_PIN_IDLE,
                           pinCfg: eic_pkg::EIC_PIN_CFG_RESET,
                           prioTwo: eic_pkg::EIC_PRIO_TWO_RESET,
                           trigA: 1'b0,
                           trigB: 1'b0,
                           pendA: 1'b0,
                           pendB: 1'b0,
                           prevA: 1'b0,
                           prevB: 1'b0,
                           levelReq: 1'b0,
                           readData: eic_pkg::EIC_ZERO_BYTE};
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign sfrReadData = state_reg.readData;
    assign extAPending = state_reg.pendA;
    assign extBPending = state_reg.pendB;
    assign extATriggerType = state_reg.trigA;
    assign extBTriggerType = state_reg.trigB;
    assign levelIrqCRequest = state_reg.levelReq;
    assign timer5Priority = state_reg.prioTwo[eic_pkg::EIC_TIMER5_BIT];
    assign timer4Priority = state_reg.prioTwo[eic_pkg::EIC_TIMER4_BIT];
    assign secondSmbusPriority = state_reg.prioTwo[eic_pkg::EIC_SMBUS_BIT];
    assign serialOnePriority = state_reg.prioTwo[eic_pkg::EIC_SERIAL_BIT];
    assign levelIrqPriority = state_reg.prioTwo[eic_pkg::EIC_LEVEL_BIT];

    // ==========================================================
    // assertions
    a_prio_timers:
    assert property (@(posedge clk) disable iff (!resetn)
        wrPrio |=> (timer5Priority == $past(sfrWriteData[5])) && (timer4Priority == $past(sfrWriteData[4])))
    else $error("timer priority bits did not follow the write");

    a_prio_smbus:
    assert property (@(posedge clk) disable iff (!resetn)
        wrPrio ##1 !wrPrio[*2] |-> secondSmbusPriority == $past(sfrWriteData[3], 2))
    else $error("smbus priority bit lost its written value");

    a_prio_serial:
    assert property (@(posedge clk) disable iff (!resetn)
        wrPrio |=> serialOnePriority == $past(sfrWriteData[1]))
    else $error("serial priority bit did not follow the write");

    a_prio_level:
    assert property (@(posedge clk) disable iff (!resetn)
        !wrPrio |=> $stable(levelIrqPriority))
    else $error("level priority bit changed without a write");

    a_reserved_zero:
    assert property (@(posedge clk) disable iff (!resetn)
        sfrRead && (sfrAddr == eic_pkg::EIC_PRIO_TWO_ADDR) |=> sfrReadData[7:6] == 2'b00)
    else $error("unused priority bits read as nonzero");

    a_level_follow:
    assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.trigA |=> extAPending == $past(activeA))
    else $error("level pending flag does not track the input");

    a_edge_clear:
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg.trigB && extBVectorAck && !edgeB && !wrCtrl |=> !extBPending)
    else $error("edge pending flag not cleared on vector");

    a_edge_set:
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg.trigA && edgeA |=> extAPending)
    else $error("edge pending flag missed an activation");

    a_sync_depth:
    assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn, 2) |-> state_reg.syncSecond == $past(port0Pins, 2))
    else $error("pin synchroniser is not two stages deep");

    a_level_gate:
    assert property (@(posedge clk) disable iff (!resetn)
        !levelIrqEnable |=> !levelIrqCRequest)
    else $error("level interrupt c requested while disabled");

    a_level_gate_on:
    assert property (@(posedge clk) disable iff (!resetn)
        levelIrqEnable && levelIrqCActive |=> levelIrqCRequest)
    else $error("level interrupt c missing while enabled and active");

    a_level_follow_b:
    assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.trigB |=> extBPending == $past(activeB))
    else $error("level pending flag b does not track the input");

    a_edge_set_b:
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg.trigB && edgeB |=> extBPending)
    else $error("edge pending flag b missed an activation");

    a_edge_clear_a:
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg.trigA && extAVectorAck && !edgeA && !wrCtrl |=> !extAPending)
    else $error("edge pending flag a not cleared on vector");

    a_edge_hold_a:
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg.trigA && extAPending && !extAVectorAck && !wrCtrl |=> extAPending)
    else $error("edge pending flag a dropped without a vector");

    a_edge_hold_b:
    assert property (@(posedge clk) disable iff (!resetn)
        state_reg.trigB && extBPending && !extBVectorAck && !wrCtrl |=> extBPending)
    else $error("edge pending flag b dropped without a vector");

    a_active_high_a:
    assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.trigA && state_reg.pinCfg[eic_pkg::EIC_A_POL_BIT] && state_reg.syncSecond[selA] |=> extAPending)
    else $error("active high input a not seen as pending");

    a_active_low_a:
    assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.trigA && !state_reg.pinCfg[eic_pkg::EIC_A_POL_BIT] && !state_reg.syncSecond[selA] |=> extAPending)
    else $error("active low input a not seen as pending");

    a_active_high_b:
    assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.trigB && state_reg.pinCfg[eic_pkg::EIC_B_POL_BIT] && state_reg.syncSecond[selB] |=> extBPending)
    else $error("active high input b not seen as pending");

    a_active_low_b:
    assert property (@(posedge clk) disable iff (!resetn)
        !state_reg.trigB && !state_reg.pinCfg[eic_pkg::EIC_B_POL_BIT] && !state_reg.syncSecond[selB] |=> extBPending)
    else $error("active low input b not seen as pending");

    a_cfg_write:
    assert property (@(posedge clk) disable iff (!resetn)
        wrCfg |=> state_reg.pinCfg == $past(sfrWriteData))
    else $error("pin configuration did not take the write");

    a_cfg_stable:
    assert property (@(posedge clk) disable iff (!resetn)
        !wrCfg |=> $stable(state_reg.pinCfg))
    else $error("pin configuration changed without a write");

    a_read_cfg:
    assert property (@(posedge clk) disable iff (!resetn)
        sfrRead && (sfrAddr == eic_pkg::EIC_PIN_CFG_ADDR) |=> sfrReadData == $past(state_reg.pinCfg))
    else $error("pin configuration read back wrong");

    a_read_ctrl:
    assert property (@(posedge clk) disable iff (!resetn)
        sfrRead && (sfrAddr == eic_pkg::EIC_TIMER_CTRL_ADDR) |=> sfrReadData == {4'h0, $past(extBPending),
            $past(extBTriggerType), $past(extAPending), $past(extATriggerType)})
    else $error("control bits read back wrong");

    a_read_hold:
    assert property (@(posedge clk) disable iff (!resetn)
        !sfrRead |=> $stable(sfrReadData))
    else $error("read data changed without a read");

    a_prio_reserved:
    assert property (@(posedge clk) disable iff (!resetn)
        (state_reg.prioTwo & ~eic_pkg::EIC_PRIO_TWO_WMASK) == eic_pkg::EIC_ZERO_BYTE)
    else $error("unused priority bits hold a one");

    a_trig_write:
    assert property (@(posedge clk) disable iff (!resetn)
        wrCtrl |=> (extATriggerType == $past(sfrWriteData[eic_pkg::EIC_TRIG_A_BIT]))
            && (extBTriggerType == $past(sfrWriteData[eic_pkg::EIC_TRIG_B_BIT])))
    else $error("trigger type bits did not take the write");

endmodule : eic_ext_irq_config

/* eic_pin_source.sv */
// partner model: interrupt sources driving the port 0 pins
`timescale 1ns/100ps
module eic_pin_source (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] raiseMask,
    input wire logic [7:0] dropMask,
    input wire logic [7:0] polarity,
    output logic [7:0] port0Pins
);
    // ==========================================================
    // request hold
    // a source keeps its line active until told to let go
    logic [7:0] srcHeld_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            srcHeld_reg <= 8'h00;
        end else begin
            srcHeld_reg <= (srcHeld_reg | raiseMask) & ~dropMask;
        end
    end
    // released lines sit at their inactive level
    // these pins are skipped by the crossbar, so only the sources drive them
    assign port0Pins = ~(srcHeld_reg ^ polarity);
endmodule : eic_pin_source

/* eic_ext_irq_config_bench.sv */
// self-checking bench for the external interrupt configuration block
`timescale 1ns/100ps
module eic_ext_irq_config_bench;
    logic clk = 1'b0;
    logic resetn, sfrWrite, sfrRead, extAVectorAck, extBVectorAck, levelIrqEnable, levelIrqCActive;
    logic [7:0] sfrAddr, sfrWriteData, sfrReadData, port0Pins, raiseMask, dropMask, polMask, prioOut;
    logic extAPending, extBPending, extATriggerType, extBTriggerType, levelIrqCRequest;
    logic timer5Priority, timer4Priority, secondSmbusPriority, serialOnePriority, levelIrqPriority;
    int err_total = 0;
    int total_checks = 0;
    assign prioOut = {2'b00, timer5Priority, timer4Priority, secondSmbusPriority, 1'b0, serialOnePriority,
        levelIrqPriority};

    eic_ext_irq_config dut (.clk(clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData), .port0Pins(port0Pins),
        .extAVectorAck(extAVectorAck), .extBVectorAck(extBVectorAck), .levelIrqEnable(levelIrqEnable),
        .levelIrqCActive(levelIrqCActive), .extAPending(extAPending), .extBPending(extBPending),
        .extATriggerType(extATriggerType), .extBTriggerType(extBTriggerType),
        .levelIrqCRequest(levelIrqCRequest), .timer5Priority(timer5Priority), .timer4Priority(timer4Priority),
        .secondSmbusPriority(secondSmbusPriority), .serialOnePriority(serialOnePriority),
        .levelIrqPriority(levelIrqPriority));
    eic_pin_source src (.clk(clk), .resetn(resetn), .raiseMask(raiseMask), .dropMask(dropMask),
        .polarity(polMask), .port0Pins(port0Pins));

    // ==========================================================
    // helpers
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWriteData = d;
        sfrWrite = 1'b1;
        tick(1);
        sfrWrite = 1'b0;
        tick(1);
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRead = 1'b1;
        tick(1);
        sfrRead = 1'b0;
        check(sfrReadData, exp);
        tick(1);
    endtask : sfr_rd
    // pulse one pin, check pending flags while held and after release
    task automatic pin_cycle(input logic [7:0] m, input logic [7:0] expOn, input logic [7:0] expOff);
        raiseMask = m;
        tick(1);
        raiseMask = 8'h00;
        tick(4);
        check({6'h00, extAPending, extBPending}, expOn);
        dropMask = m;
        tick(1);
        dropMask = 8'h00;
        tick(4);
        check({6'h00, extAPending, extBPending}, expOff);
    endtask : pin_cycle
    task automatic ack(input logic a, input logic b);
        extAVectorAck = a;
        extBVectorAck = b;
        tick(1);
        extAVectorAck = 1'b0;
        extBVectorAck = 1'b0;
        tick(1);
    endtask : ack
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // watchdog: whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        stop_test;
    end

    // ==========================================================
    // tests
    initial begin
        logic [2:0] sel;
        {resetn, sfrWrite, sfrRead, extAVectorAck, extBVectorAck, levelIrqEnable, levelIrqCActive} = 7'h00;
        {sfrAddr, sfrWriteData, raiseMask, dropMask, polMask} = 40'h0;
        repeat (10) @(posedge clk);
        #5 resetn = 1'b1;
        tick(1);
        check({6'h00, extAPending, extBPending}, 8'h00);
        tick(1);
        check({6'h00, extAPending, extBPending}, 8'h00);
        sfr_rd(eic_pkg::EIC_PIN_CFG_ADDR, 8'h01);
        sfr_rd(eic_pkg::EIC_PRIO_TWO_ADDR, 8'h00);
        sfr_rd(eic_pkg::EIC_TIMER_CTRL_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            sfr_wr(eic_pkg::EIC_PRIO_TWO_ADDR, 8'h01 << i);
            check(prioOut, (8'h01 << i) & 8'h3b);
            sfr_rd(eic_pkg::EIC_PRIO_TWO_ADDR, (8'h01 << i) & 8'h3f);
        end
        // level mode: every pin, both polarities; b watches the mirrored pin
        for (int p = 0; p < 16; p++) begin
            sel = p[2:0];
            polMask = {8{p[3]}};
            sfr_wr(eic_pkg::EIC_PIN_CFG_ADDR, {p[3], ~sel, p[3], sel});
            pin_cycle(8'h01 << sel, 8'h02, 8'h00);
            pin_cycle(8'h01 << ~sel, 8'h01, 8'h00);
        end
        raiseMask = 8'h01 << sel;
        tick(5);
        ack(1'b1, 1'b0);
        check({6'h00, extAPending, extBPending}, 8'h02);
        dropMask = raiseMask;
        raiseMask = 8'h00;
        tick(1);
        dropMask = 8'h00;
        // edge mode on reset pin choice, active low
        polMask = 8'h00;
        sfr_wr(eic_pkg::EIC_PIN_CFG_ADDR, 8'h01);
        tick(4);
        sfr_wr(eic_pkg::EIC_TIMER_CTRL_ADDR, 8'h05);
        check({6'h00, extATriggerType, extBTriggerType}, 8'h03);
        pin_cycle(8'h02, 8'h02, 8'h02);
        sfr_rd(eic_pkg::EIC_TIMER_CTRL_ADDR, 8'h07);
        ack(1'b1, 1'b0);
        sfr_rd(eic_pkg::EIC_TIMER_CTRL_ADDR, 8'h05);
        pin_cycle(8'h01, 8'h01, 8'h01);
        sfr_rd(eic_pkg::EIC_TIMER_CTRL_ADDR, 8'h0d);
        ack(1'b0, 1'b1);
        check({6'h00, extAPending, extBPending}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            levelIrqEnable = k[1];
            levelIrqCActive = k[0];
            tick(2);
            check({7'h00, levelIrqCRequest}, {7'h00, k[1] & k[0]});
        end
        sfr_wr(8'h55, 8'hff);
        sfr_rd(8'h55, 8'h00);
        sfr_rd(eic_pkg::EIC_PIN_CFG_ADDR, 8'h01);
        stop_test;
    end
endmodule : eic_ext_irq_config_bench
